// >>> design/mpd_pkg.sv
// Package: register map, field positions, resets and bus types of the PWM block
package mpd_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [29:0] MPD_IDX_MAIN = 30'h00FFE380;
	localparam logic [29:0] MPD_IDX_AUX = 30'h00FFE381;
	localparam logic [29:0] MPD_IDX_DEAD = 30'h00FFE382;
	localparam logic [29:0] MPD_IDX_MPF = 30'h00FFE383;
	localparam logic [29:0] MPD_IDX_TIME = 30'h00FFE3A0;
	localparam logic [29:0] MPD_IDX_DUTY0 = 30'h00FFE3A1;
	localparam logic [29:0] MPD_IDX_OVR = 30'h00FFE3A7;
	localparam logic [29:0] MPD_IDX_STAT = 30'h00FFE3A8;

	// ==========================================================
	// Field positions
	localparam int MPD_MAIN_OFF = 7;
	localparam int MPD_MAIN_OVR = 6;
	localparam int MPD_MAIN_ALIGN = 5;
	localparam int MPD_MAIN_TRIG = 3;
	localparam int MPD_MAIN_RDY = 1;
	localparam int MPD_MAIN_EN = 0;
	localparam int MPD_AUX_RATE = 6;
	localparam int MPD_AUX_IND = 5;
	localparam int MPD_AUX_POL = 2;
	localparam int MPD_AUX_CLOCK_DIVIDER_FIELD = 0;
	localparam int MPD_TIME_EXT = 15;

	// ==========================================================
	// Values after reset and fixed counts
	localparam logic [7:0] MPD_MAIN_RST = 8'h00;
	localparam logic [7:0] MPD_AUX_RST = 8'h00;
	localparam logic [7:0] MPD_DEAD_RST = 8'h01;
	localparam logic [7:0] MPD_MPF_RST = 8'h00;
	localparam logic [7:0] MPD_OVR_RST = 8'h00;
	localparam logic [15:0] MPD_TIME_RST = 16'h0FFF;
	localparam logic [13:0] MPD_DUTY_RST = 14'h0000;
	localparam logic [8:0] MPD_DEAD_MAX = 9'h100;
	localparam logic [1:0] MPD_RESP_OKAY = 2'h0;
	localparam logic [1:0] MPD_RESP_DECERR = 2'h3;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} mpd_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} mpd_axi_rsp_s;

	typedef enum logic [1:0] {
		MPD_UP = 2'b01,
		MPD_DOWN = 2'b10
	} mpd_dir_e;
endpackage

// >>> design/mpd_top.sv
// Motor PWM control, dead band and pulse filter with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module mpd_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire mpd_pkg::mpd_axi_req_s axi_req,
	output var mpd_pkg::mpd_axi_rsp_s axi_rsp,
	input wire logic external_modulator_clock_in,
	output logic [5:0] pwm_out,
	output logic [5:0] pwm_drive_en,
	output logic converter_trigger
);
	import mpd_pkg::*;

	// ==========================================================
	// Declarations
	logic [7:0] main_q, aux_q, dead_q, mpf_q, ovr_q;
	logic dead_lock_q;
	logic [15:0] time_q;
	logic [13:0] duty_q [6];
	logic [13:0] duty_w_q [6];
	logic [1:0] clock_divider_field_w_q, rate_w_q;
	logic [11:0] per_w_q, cnt_q, per_m1;
	mpd_dir_e dir_q;
	logic [2:0] pre_cnt_q, rl_cnt_q, pre_lim, rl_lim;
	logic mod_on_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
	logic aw_have_q, w_have_q;
	logic [29:0] widx_q, ridx;
	logic [31:0] wdata_q, rd_data;
	logic [3:0] wstrb_q;
	logic do_wr, en, in_tick, pre_tick, per_end, reload_evt;
	logic wr_main, wr_aux, wr_dead, wr_mpf, wr_time, wr_ovr;
	logic [5:0] raw, want, filt, pol, out_off;

	function automatic logic idx_hit(input logic [29:0] idx);
		idx_hit = (idx >= MPD_IDX_MAIN && idx <= MPD_IDX_MPF) ||
			(idx >= MPD_IDX_TIME && idx <= MPD_IDX_STAT);
	endfunction

	// ==========================================================
	// AXI4-Lite slave
	assign do_wr = aw_have_q && w_have_q && !axi_rsp.bvalid;
	assign ridx = axi_req.araddr[31:2];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			axi_rsp <= '0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			widx_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			axi_rsp.awready <= axi_req.awvalid && !aw_have_q &&
				!axi_rsp.awready;
			axi_rsp.wready <= axi_req.wvalid && !w_have_q &&
				!axi_rsp.wready;
			axi_rsp.arready <= axi_req.arvalid && !axi_rsp.rvalid &&
				!axi_rsp.arready;
			if (axi_req.awvalid && axi_rsp.awready) begin
				aw_have_q <= 1'b1;
				widx_q <= axi_req.awaddr[31:2];
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				w_have_q <= 1'b1;
				wdata_q <= axi_req.wdata;
				wstrb_q <= axi_req.wstrb;
			end
			if (do_wr) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				axi_rsp.bvalid <= 1'b1;
				axi_rsp.bresp <= idx_hit(widx_q) ? MPD_RESP_OKAY :
					MPD_RESP_DECERR;
			end else if (axi_rsp.bvalid && axi_req.bready) begin
				axi_rsp.bvalid <= 1'b0;
			end
			if (axi_req.arvalid && axi_rsp.arready) begin
				axi_rsp.rvalid <= 1'b1;
				axi_rsp.rdata <= rd_data;
				axi_rsp.rresp <= idx_hit(ridx) ? MPD_RESP_OKAY :
					MPD_RESP_DECERR;
			end else if (axi_rsp.rvalid && axi_req.rready) begin
				axi_rsp.rvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_main = do_wr && wstrb_q[0] && widx_q == MPD_IDX_MAIN;
		wr_aux = do_wr && wstrb_q[0] && widx_q == MPD_IDX_AUX;
		wr_dead = do_wr && wstrb_q[0] && widx_q == MPD_IDX_DEAD;
		wr_mpf = do_wr && wstrb_q[0] && widx_q == MPD_IDX_MPF;
		wr_time = do_wr && widx_q == MPD_IDX_TIME;
		wr_ovr = do_wr && wstrb_q[0] && widx_q == MPD_IDX_OVR;
	end

	// Reads of buffered fields return the holding copy
	always_comb begin
		rd_data = '0;
		if (ridx == MPD_IDX_MAIN) begin
			rd_data[7:0] = main_q;
		end else if (ridx == MPD_IDX_AUX) begin
			rd_data[7:0] = aux_q;
		end else if (ridx == MPD_IDX_DEAD) begin
			rd_data[7:0] = dead_q;
		end else if (ridx == MPD_IDX_MPF) begin
			rd_data[7:0] = mpf_q;
		end else if (ridx == MPD_IDX_TIME) begin
			rd_data[15:0] = time_q;
		end else if (ridx >= MPD_IDX_DUTY0 && ridx < MPD_IDX_OVR) begin
			rd_data[13:0] = duty_q[3'(ridx - MPD_IDX_DUTY0)];
		end else if (ridx == MPD_IDX_OVR) begin
			rd_data[7:0] = ovr_q;
		end else if (ridx == MPD_IDX_STAT) begin
			rd_data = {5'h00, pwm_out, mod_on_q, dir_q == MPD_DOWN,
				1'b0, clock_divider_field_w_q, rate_w_q, 2'h0, cnt_q};
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			main_q <= MPD_MAIN_RST;
		end else begin
			// Ready is consumed by the transfer; a write in the same cycle wins
			if (reload_evt) begin
				main_q[MPD_MAIN_RDY] <= 1'b0;
			end
			if (wr_main) begin
				main_q <= wdata_q[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aux_q <= MPD_AUX_RST;
			mpf_q <= MPD_MPF_RST;
			ovr_q <= MPD_OVR_RST;
			time_q <= MPD_TIME_RST;
		end else begin
			if (wr_aux) begin
				aux_q <= wdata_q[7:0];
			end
			if (wr_mpf) begin
				mpf_q <= wdata_q[7:0];
			end
			if (wr_ovr) begin
				ovr_q <= wdata_q[7:0];
			end
			if (wr_time && wstrb_q[0]) begin
				time_q[7:0] <= wdata_q[7:0];
			end
			if (wr_time && wstrb_q[1]) begin
				time_q[15:8] <= wdata_q[15:8];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dead_q <= MPD_DEAD_RST;
			dead_lock_q <= 1'b0;
		end else if (wr_dead && !dead_lock_q) begin
			dead_q <= wdata_q[7:0];
			dead_lock_q <= 1'b1;
		end
	end

	dead_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		dead_lock_q && wr_dead |=> $stable(dead_q))
		else $error("dead band register changed after first write");

	// ==========================================================
	// Clock source, prescaler and reload rate
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			ext_lvl_q <= 1'b0;
		end else begin
			ext_s1_q <= external_modulator_clock_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q == ext_s3_q) begin
				ext_lvl_q <= ext_s3_q;
			end
		end
	end

	assign en = main_q[MPD_MAIN_EN];
	assign in_tick = time_q[MPD_TIME_EXT] ?
		(ext_s2_q && ext_s3_q && !ext_lvl_q) : 1'b1;

	always_comb begin
		case (clock_divider_field_w_q)
			2'h0: pre_lim = 3'h0;
			2'h1: pre_lim = 3'h1;
			2'h2: pre_lim = 3'h3;
			default: pre_lim = 3'h7;
		endcase
		case (rate_w_q)
			2'h0: rl_lim = 3'h0;
			2'h1: rl_lim = 3'h1;
			2'h2: rl_lim = 3'h3;
			default: rl_lim = 3'h7;
		endcase
	end

	assign pre_tick = en && in_tick && pre_cnt_q == pre_lim;
	assign per_m1 = per_w_q - 12'h001;
	assign per_end = pre_tick &&
		((dir_q == MPD_UP && cnt_q >= per_m1 && !main_q[MPD_MAIN_ALIGN]) ||
		(dir_q == MPD_DOWN && cnt_q <= 12'h001));
	assign reload_evt = per_end && rl_cnt_q >= rl_lim;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || !en) begin
			pre_cnt_q <= '0;
		end else if (in_tick) begin
			pre_cnt_q <= pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rl_cnt_q <= '0;
			rate_w_q <= MPD_AUX_RST[MPD_AUX_RATE +: 2];
		end else if (!en) begin
			rl_cnt_q <= '0;
		end else if (per_end) begin
			rl_cnt_q <= reload_evt ? 3'h0 : rl_cnt_q + 3'h1;
			rate_w_q <= aux_q[MPD_AUX_RATE +: 2];
		end
	end

	rate_apply_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		per_end && en |=> rate_w_q == $past(aux_q[7:6]))
		else $error("reload rate not taken at period end");

	// ==========================================================
	// Master counter; centre mode counts up then down
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !en) begin
			cnt_q <= '0;
			dir_q <= MPD_UP;
		end else if (pre_tick) begin
			case (dir_q)
				MPD_UP: begin
					if (cnt_q >= per_m1 && main_q[MPD_MAIN_ALIGN]) begin
						cnt_q <= per_w_q;
						dir_q <= MPD_DOWN;
					end else if (cnt_q >= per_m1) begin
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 12'h001;
					end
				end
				MPD_DOWN: begin
					if (cnt_q <= 12'h001) begin
						cnt_q <= '0;
						dir_q <= MPD_UP;
					end else begin
						cnt_q <= cnt_q - 12'h001;
					end
				end
				default: dir_q <= MPD_UP;
			endcase
		end
	end

	sequence en_low_s;
		!en [*2];
	endsequence
	disable_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		en_low_s |-> cnt_q == 12'h000 && pwm_out == $past(pol))
		else $error("counter or outputs active while disabled");

	// ==========================================================
	// Working registers loaded at a reload event
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clock_divider_field_w_q <= MPD_AUX_RST[MPD_AUX_CLOCK_DIVIDER_FIELD +: 2];
			per_w_q <= MPD_TIME_RST[11:0];
		end else if (reload_evt && main_q[MPD_MAIN_RDY]) begin
			clock_divider_field_w_q <= aux_q[MPD_AUX_CLOCK_DIVIDER_FIELD +: 2];
			// A zero period would wrap only after 4096 ticks; treat it as one
			per_w_q <= (time_q[11:0] == 12'h000) ? 12'h001 : time_q[11:0];
		end
	end

	ready_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reload_evt && main_q[MPD_MAIN_RDY] && time_q[11:0] != 12'h000 |=>
		per_w_q == $past(time_q[11:0]) && clock_divider_field_w_q == $past(aux_q[1:0]))
		else $error("holding values not copied at reload");

	keep_work_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reload_evt && !main_q[MPD_MAIN_RDY] |=>
		$stable(per_w_q) && $stable(clock_divider_field_w_q) && $stable(duty_w_q[0]))
		else $error("working values changed without ready");

	// ==========================================================
	// Modulator release after forced-off
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !main_q[MPD_MAIN_OFF]) begin
			mod_on_q <= 1'b0;
		end else if (reload_evt) begin
			mod_on_q <= 1'b1;
		end
	end

	reenable_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!mod_on_q && !reload_evt |=> !mod_on_q)
		else $error("modulator resumed without a reload event");

	// ==========================================================
	// Per-channel compare and duty buffering
	for (genvar i = 0; i < 6; i++) begin : g_ch
		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				duty_q[i] <= MPD_DUTY_RST;
				duty_w_q[i] <= MPD_DUTY_RST;
			end else begin
				if (do_wr && widx_q == MPD_IDX_DUTY0 + 30'(i)) begin
					if (wstrb_q[0]) begin
						duty_q[i][7:0] <= wdata_q[7:0];
					end
					if (wstrb_q[1]) begin
						duty_q[i][13:8] <= wdata_q[13:8];
					end
				end
				if (reload_evt && main_q[MPD_MAIN_RDY]) begin
					duty_w_q[i] <= duty_q[i];
				end
			end
		end
		assign raw[i] = duty_w_q[i][13] ? 1'b0 :
			(duty_w_q[i][12:0] > {1'b0, per_w_q}) ? 1'b1 :
			({1'b0, cnt_q} < duty_w_q[i][12:0]);
		assign pol[i] = aux_q[MPD_AUX_POL + i / 2];
	end

	// ==========================================================
	// Dead band per complementary pair
	for (genvar p = 0; p < 3; p++) begin : g_pair
		logic [8:0] db_cnt_q;
		logic db_prev_q;
		always_ff @(posedge sys_clk) begin
			if (!rst_n || !en) begin
				db_cnt_q <= '0;
				db_prev_q <= 1'b0;
			end else if (raw[2 * p] != db_prev_q) begin
				db_prev_q <= raw[2 * p];
				// The edge cycle is already part of the gap
				db_cnt_q <= (dead_q == 8'h00) ?
					MPD_DEAD_MAX - 9'h001 : {1'b0, dead_q} - 9'h001;
			end else if (db_cnt_q != 9'h000 && in_tick) begin
				db_cnt_q <= db_cnt_q - 9'h001;
			end
		end
		always_comb begin
			if (aux_q[MPD_AUX_IND]) begin
				want[2 * p] = raw[2 * p];
				want[2 * p + 1] = raw[2 * p + 1];
			end else if (db_cnt_q != 9'h000 || raw[2 * p] != db_prev_q) begin
				want[2 * p] = 1'b0;
				want[2 * p + 1] = 1'b0;
			end else begin
				want[2 * p] = raw[2 * p];
				want[2 * p + 1] = !raw[2 * p];
			end
		end
	end

	dead_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!aux_q[MPD_AUX_IND] && (g_pair[0].db_cnt_q != 9'h000 ||
		raw[0] != g_pair[0].db_prev_q) |->
		!want[0] && !want[1])
		else $error("pair driven during dead band");

	// ==========================================================
	// Minimum pulse filter; widths count prescaled ticks
	for (genvar i = 0; i < 6; i++) begin : g_flt
		logic lvl_q;
		logic [7:0] age_q;
		always_ff @(posedge sys_clk) begin
			if (!rst_n || !en) begin
				lvl_q <= 1'b0;
				age_q <= '0;
			end else if (want[i] != lvl_q && age_q >= mpf_q) begin
				lvl_q <= want[i];
				age_q <= '0;
			end else if (pre_tick && age_q != 8'hFF) begin
				age_q <= age_q + 8'h01;
			end
		end
		assign filt[i] = lvl_q;
		// Forced-off acts at once, not a cycle later through mod_on_q
		assign out_off[i] = !en || !mod_on_q ||
			!main_q[MPD_MAIN_OFF] ||
			(main_q[MPD_MAIN_OVR] && ovr_q[i]);
	end

	// ==========================================================
	// Pins and converter trigger
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pwm_out <= '0;
			pwm_drive_en <= '0;
			converter_trigger <= 1'b0;
		end else begin
			pwm_out <= (filt & ~out_off) ^ pol;
			pwm_drive_en <= {6{en}};
			converter_trigger <= main_q[MPD_MAIN_TRIG] && per_end;
		end
	end

	off_forced_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!main_q[MPD_MAIN_OFF] |=> pwm_out == $past(pol))
		else $error("outputs not off while forced off");

	override_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		main_q[MPD_MAIN_OVR] && ovr_q[0] |=> pwm_out[0] == $past(pol[0]))
		else $error("override bit did not force output off");

	trig_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		converter_trigger |-> $past(main_q[MPD_MAIN_TRIG] && per_end))
		else $error("trigger pulse without enable or period end");

endmodule
`default_nettype wire

// >>> tb/mpd_gate_model.sv
// Gate-driver model of the inverter stage: counts shoot-through cycles
`timescale 1ns/10ps
`default_nettype none
module mpd_gate_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [5:0] pwm_out,
	input wire logic [5:0] pwm_drive_en,
	input wire logic [2:0] act_low,
	output logic [15:0] shoot_cnt
);
	logic [2:0] both;
	// ==========================================================
	// Leg overlap
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			both[p] = pwm_drive_en[2*p] && pwm_drive_en[2*p+1]
				&& (pwm_out[2*p] != act_low[p])
				&& (pwm_out[2*p+1] != act_low[p]);
		end
	end
	// Both legs on shorts the rail, so every such cycle is counted
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			shoot_cnt <= 16'h0000;
		end else if (|both) begin
			shoot_cnt <= shoot_cnt + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// >>> tb/mpd_top_tb_top.sv
// Testbench: register access and PWM pin behaviour
`timescale 1ns/10ps
`default_nettype none
module mpd_top_tb_top;
	import mpd_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ext_clk = 1'b0;
	logic ext_run = 1'b0;
	logic [1:0] ext_div = 2'h0;
	logic [15:0] shoot_base;
	mpd_axi_req_s req = '0;
	mpd_axi_rsp_s rsp;
	logic [5:0] pwm_out;
	logic [5:0] pwm_drive_en;
	logic converter_trigger;
	logic [2:0] act_low = 3'h0;
	logic [15:0] shoot_cnt;
	int failures = 0;
	int n_compared = 0;
	int trig_n;
	int gap_n;
	int hi [6];
	logic [31:0] rv;
	logic [1:0] resp;

	always #2.5 sys_clk = ~sys_clk;

	// External input clock: four system cycles a period while running
	always @(posedge sys_clk) begin
		ext_div <= ext_div + 2'h1;
		ext_clk <= ext_run && ext_div[1];
	end

	mpd_top mpd_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .axi_req(req),
		.axi_rsp(rsp), .external_modulator_clock_in(ext_clk),
		.pwm_out(pwm_out), .pwm_drive_en(pwm_drive_en),
		.converter_trigger(converter_trigger));
	mpd_gate_model mpd_gate_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.pwm_out(pwm_out), .pwm_drive_en(pwm_drive_en),
		.act_low(act_low), .shoot_cnt(shoot_cnt));

	// ==========================================================
	// Shared tasks
	task automatic wrap_up();
		if (failures == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic ck(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			wrap_up();
		end
	endtask

	task automatic wait_c(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Address and data offered together, each released when taken
	task automatic wr(input logic [29:0] i, input logic [31:0] d);
		int n;
		req.awaddr <= {i, 2'b00};
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge sys_clk);
			if (rsp.awready === 1'b1) begin
				req.awvalid <= 1'b0;
			end
			if (rsp.wready === 1'b1) begin
				req.wvalid <= 1'b0;
			end
			if (rsp.bvalid === 1'b1) begin
				break;
			end
		end
		tmo(n, 64);
		resp = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [29:0] i);
		int n;
		req.araddr <= {i, 2'b00};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge sys_clk);
			if (rsp.arready === 1'b1) begin
				req.arvalid <= 1'b0;
			end
			if (rsp.rvalid === 1'b1) begin
				break;
			end
		end
		tmo(n, 64);
		rv = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rdck(input logic [29:0] i, input logic [31:0] e);
		rd(i);
		ck(rv, e);
	endtask

	// Per-cycle tallies of trigger pulses, high pins and pair-0 gaps
	task automatic watch(input int n);
		trig_n = 0;
		gap_n = 0;
		for (int i = 0; i < 6; i++) hi[i] = 0;
		repeat (n) begin
			@(posedge sys_clk);
			trig_n += int'(converter_trigger === 1'b1);
			gap_n += int'(pwm_out[1:0] === 2'b00);
			for (int i = 0; i < 6; i++) hi[i] += int'(pwm_out[i] === 1'b1);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] stat;
		rdck(MPD_IDX_MAIN, 32'h00);
		rdck(MPD_IDX_AUX, 32'h00);
		rdck(MPD_IDX_DEAD, 32'h01);
		rdck(MPD_IDX_MPF, 32'h00);
		rd(30'h00FFE3B0);
		ck({30'h0, resp}, {30'h0, MPD_RESP_DECERR});
		wr(MPD_IDX_MAIN, 32'h14);
		rdck(MPD_IDX_MAIN, 32'h14);
		wr(MPD_IDX_AUX, 32'hFF);
		rdck(MPD_IDX_AUX, 32'hFF);
		wr(MPD_IDX_AUX, 32'h00);
		wr(MPD_IDX_DEAD, 32'h05);
		wr(MPD_IDX_DEAD, 32'h09);
		ck({30'h0, resp}, {30'h0, MPD_RESP_OKAY});
		rdck(MPD_IDX_DEAD, 32'h05);
		ck({26'h0, pwm_drive_en}, 32'h00);
		ck({26'h0, pwm_out}, 32'h00);
		rd(MPD_IDX_STAT);
		stat = rv;
		wait_c(30);
		rdck(MPD_IDX_STAT, stat);
	endtask

	task automatic t_run();
		wr(MPD_IDX_TIME, 32'h28);
		for (int i = 0; i < 6; i++) wr(MPD_IDX_DUTY0 + 30'(i), 32'h14);
		wr(MPD_IDX_MAIN, 32'h83);
		// Working period after reset is 4095 cycles; reload comes after it
		wait_c(4200);
		ck({26'h0, pwm_drive_en}, 32'h3F);
		watch(80);
		ck(32'(trig_n), 32'h0);
		ck(32'(hi[0] > 0 && hi[0] < 80), 32'h1);
		ck({16'h0, shoot_cnt}, 32'h0);
		ck(32'(gap_n), 32'h14);
		rdck(MPD_IDX_MAIN, 32'h81);
	endtask

	task automatic t_off();
		wr(MPD_IDX_MAIN, 32'h01);
		wait_c(2);
		watch(80);
		ck(32'(hi[0] + hi[1] + hi[2] + hi[3] + hi[4] + hi[5]), 32'h0);
		wr(MPD_IDX_MAIN, 32'h81);
		watch(90);
		ck(32'(hi[0] > 0), 32'h1);
	endtask

	task automatic t_trig();
		wr(MPD_IDX_MAIN, 32'h89);
		watch(80);
		ck(32'(trig_n), 32'h2);
		wr(MPD_IDX_MAIN, 32'hA9);
		wait_c(100);
		watch(160);
		ck(32'(trig_n), 32'h2);
		wr(MPD_IDX_MAIN, 32'h89);
		wait_c(100);
	endtask

	task automatic t_reload();
		int n;
		wr(MPD_IDX_TIME, 32'h14);
		wait_c(100);
		watch(80);
		ck(32'(trig_n), 32'h2);
		wr(MPD_IDX_MAIN, 32'h8B);
		wait_c(100);
		watch(80);
		ck(32'(trig_n), 32'h4);
		wr(MPD_IDX_AUX, 32'h01);
		wait_c(100);
		rd(MPD_IDX_STAT);
		ck({30'h0, rv[17:16]}, 32'h0);
		wr(MPD_IDX_MAIN, 32'h8B);
		wait_c(100);
		watch(80);
		ck(32'(trig_n), 32'h2);
		wr(MPD_IDX_AUX, 32'hC1);
		wait_c(60);
		rd(MPD_IDX_STAT);
		ck({30'h0, rv[15:14]}, 32'h3);
		wr(MPD_IDX_MAIN, 32'h8B);
		for (n = 0; n < 200; n++) begin
			rd(MPD_IDX_MAIN);
			if (rv[1] === 1'b0) begin
				break;
			end
		end
		tmo(n, 200);
		// Eight periods of 40 cycles between reloads now
		wr(MPD_IDX_MAIN, 32'h8B);
		wait_c(200);
		rdck(MPD_IDX_MAIN, 32'h8B);
		wait_c(150);
		rdck(MPD_IDX_MAIN, 32'h89);
		wr(MPD_IDX_AUX, 32'h00);
		wr(MPD_IDX_TIME, 32'h28);
		wr(MPD_IDX_MAIN, 32'h8B);
		wait_c(400);
	endtask

	task automatic t_pol_ovr();
		wr(MPD_IDX_AUX, 32'h04);
		wr(MPD_IDX_MAIN, 32'h01);
		act_low <= 3'h1;
		watch(40);
		ck({26'h0, pwm_out}, 32'h03);
		wr(MPD_IDX_OVR, 32'h01);
		wr(MPD_IDX_MAIN, 32'hC1);
		wait_c(100);
		// Polarity flips glitch the model, so count only this window
		shoot_base = shoot_cnt;
		watch(80);
		ck(32'(hi[0]), 32'h50);
		ck(32'(hi[2] > 0 && hi[2] < 80), 32'h1);
		ck({16'h0, shoot_cnt - shoot_base}, 32'h0);
		wr(MPD_IDX_OVR, 32'h00);
		wr(MPD_IDX_AUX, 32'h00);
		act_low <= 3'h0;
	endtask

	task automatic t_indep();
		wr(MPD_IDX_MPF, 32'h0A);
		wr(MPD_IDX_AUX, 32'h20);
		wr(MPD_IDX_DUTY0, 32'h2000);
		wr(MPD_IDX_DUTY0 + 30'h1, 32'h0FFF);
		wr(MPD_IDX_DUTY0 + 30'h4, 32'h02);
		wr(MPD_IDX_MAIN, 32'h83);
		wait_c(100);
		shoot_base = shoot_cnt;
		watch(80);
		ck(32'(hi[0]), 32'h0);
		ck(32'(hi[1]), 32'h50);
		ck(32'(hi[4] == 0 || hi[4] >= 20), 32'h1);
		ck(32'(shoot_cnt != shoot_base), 32'h1);
	endtask

	// External input: one tick per four cycles, period 40 ticks
	task automatic t_ext();
		wr(MPD_IDX_MAIN, 32'h89);
		ext_run <= 1'b1;
		wr(MPD_IDX_TIME, 32'h8028);
		wait_c(400);
		watch(320);
		ck(32'(trig_n), 32'h2);
		ext_run <= 1'b0;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_run();
		t_off();
		t_trig();
		t_reload();
		t_pol_ovr();
		t_indep();
		t_ext();
		wrap_up();
	end
endmodule
`default_nettype wire
